// ==== verilog/fdcc_pkg.sv ====
/*
 package for the configure / register-dump command slice of a floppy
 controller: register offsets, field positions, reset values, opcodes,
 timing figures and the carrier structs. assumes nothing of its users.
*/
package fdcc_pkg;

   // host register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] OFS_DATA    = 4'h0;
   localparam logic [3:0] OFS_STATUS  = 4'h1;
   localparam logic [3:0] OFS_CTRL    = 4'h2;
   localparam logic [3:0] OFS_INT_ST  = 4'h3;
   localparam logic [3:0] OFS_INT_CLR = 4'h4;
   localparam logic [3:0] OFS_INT_EN  = 4'h5;

   // main status bits
   localparam int ST_READY_BIT = 7;
   localparam int ST_DIR_BIT   = 6;
   localparam int ST_BUSY_BIT  = 4;
   // control bits
   localparam int CTRL_SRST_BIT = 0;
   // interrupt bits
   localparam int INT_W         = 3;
   localparam int INT_RESET_BIT = 0;
   localparam int INT_INVAL_BIT = 1;
   localparam int INT_DONE_BIT  = 2;

   // opcodes and answers
   localparam logic [7:0] OPC_CONFIGURE     = 8'h13;
   localparam logic [7:0] OPC_REGISTER_DUMP = 8'h0E;
   localparam logic [7:0] INVALID_STATUS    = 8'h80;
   localparam logic [1:0] CFG_ARG_COUNT     = 2'h3;
   localparam logic [3:0] DUMP_LEN          = 4'hA;

   // third configure byte fields
   localparam int CFG_SEEK_BIT = 6;
   localparam int CFG_BUF_BIT  = 5;
   localparam int CFG_POLL_BIT = 4;
   localparam int CFG_THR_LSB  = 0;
   localparam int CFG_THR_W    = 4;

   // defaults
   localparam logic       RST_SEEK_EN  = 1'b0;
   localparam logic       RST_BUF_DIS  = 1'b1;
   localparam logic       RST_POLL_DIS = 1'b0;
   localparam logic [3:0] RST_THR_LVL  = 4'h0;
   localparam logic [7:0] RST_PRECOMP  = 8'h00;

   // polling window after reset
   localparam longint CLK_HZ       = 200000000;
   localparam longint POLL_WIN_MS  = 500;
   localparam int     POLL_CYCLES  =
      int'((POLL_WIN_MS * CLK_HZ) / 1000);
   localparam int     TMR_W        = 27;

   typedef struct packed {
      logic       implied_seek_enable;
      logic       buffer_disable;
      logic       polling_disable;
      logic [3:0] buffer_threshold;
      logic [7:0] precomp_start_track;
   } fdcc_cfg_type;

   // parameters owned by other command blocks, shown by the dump
   typedef struct packed {
      logic [3:0][7:0] present_track_value;
      logic [3:0]      step_rate_time;
      logic [3:0]      delay_after_processing;
      logic [6:0]      delay_before_processing;
      logic            dma_mode;
      logic [7:0]      end_of_track_sector;
      logic [3:0]      per_drive_config;
      logic [1:0]      group_drive_config;
   } fdcc_dump_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } fdcc_bus_type;

endpackage

// ==== verilog/fdcc_top.sv ====
/*
 configure and register-dump command interpreter of a floppy controller,
 with hardware reset and lock-aware software reset of the configure parameters,
 polling reset interrupt and a small interrupt status/enable block.
 assumes: one 200 MHz clock; the dump inputs and lock bit come from
 other command blocks on the same clock; the host uses the plain
 register port, never both strobes at once.
*/
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// R1 - configure is opcode, zero byte, mode byte, precomp track; no result
// R2 - hardware reset returns all configure parameters to defaults
// R3 - threshold 00h-0Fh; soft reset zeroes it unless lock is set
// R4 - host should pick larger threshold when slow, smaller when fast
// R5 - polling-disable 0 enables polling; soft reset always clears it
// R6 - with polling enabled an interrupt is raised after reset
// R7 - polling disabled within 500 ms of reset suppresses reset interrupt
// R8 - buffer-disable defaults 1; soft reset sets it unless lock set
// R9 - implied-seek enable forces implied seeks; mode bit can also enable
// R10 - implied seeks enabled mean seek before read/write/scan/verify
// R11 - precomp start track 00h-FFh; soft reset zeroes it unless locked
// R12 - register dump takes only opcode and returns exactly ten bytes
// R13 - dump bytes one to four are present track of drives 0 to 3
// R14 - then step/delay, delay/dma, sectors, lock/config, mode byte, precomp
// R15 - dumped parameters default on resets, locked ones spared by soft
// R16 - lock bit decides whether soft reset keeps lockable parameters
// R17 - an undefined opcode goes straight to result with status 80h
// R18 - lock 0 soft reset defaults lockable bits; lock 1 leaves them
// R19 - bytes pass one at a time; next result only after a read
module fdcc_top
   import fdcc_pkg::*;
#(
   parameter int POLL_WINDOW_CYCLES = POLL_CYCLES
)(
   input  wire logic                CLK_SYS_I,
   input  wire logic                RST_N_I,
   input  wire logic [ADDR_W-1:0]   ADDR_I,
   input  wire logic [DATA_W-1:0]   WDATA_I,
   input  wire logic                WR_I,
   input  wire logic                RD_I,
   output logic      [DATA_W-1:0]   RDATA_O,
   input  wire logic                LOCK_I,
   input  wire logic                MODE_IMPLIED_SEEK_I,
   input  wire fdcc_dump_type       DUMP_I,
   output logic                     IMPLIED_SEEK_O,
   output logic                     BUFFER_ENABLE_O,
   output logic [CFG_THR_W-1:0]     BUFFER_THRESHOLD_O,
   output logic                     POLLING_ENABLE_O,
   output logic [7:0]               PRECOMP_START_TRACK_O,
   output logic                     IRQ_O
);

   typedef enum logic [2:0] {
      S_IDLE   = 3'b001,
      S_CFG    = 3'b010,
      S_RESULT = 3'b100
   } fdcc_state_type;

   fdcc_bus_type   bus;
   fdcc_state_type state_r;
   fdcc_cfg_type   cfg_r;
   logic [1:0]     arg_cnt_r;
   logic [3:0]     res_idx_r;
   logic [3:0]     res_len_r;
   logic           res_inval_r;
   logic [INT_W-1:0] int_st_r;
   logic [INT_W-1:0] int_en_r;
   logic [INT_W-1:0] int_set;
   logic [INT_W-1:0] int_clr;
   logic [TMR_W-1:0] tmr_r;
   logic           tmr_run_r;
   logic           srst;
   logic           data_wr;
   logic           data_rd;
   logic [7:0]     res_byte;

   assign bus.addr  = ADDR_I;
   assign bus.wdata = WDATA_I;
   assign bus.wr    = WR_I;
   assign bus.rd    = RD_I;

   assign srst    = bus.wr && bus.addr == OFS_CTRL
                    && bus.wdata[CTRL_SRST_BIT];
   assign data_wr = bus.wr && bus.addr == OFS_DATA;
   assign data_rd = bus.rd && bus.addr == OFS_DATA;

   // one dump byte by index; used by the data read path
   function automatic logic [7:0] dump_byte(
      input logic [3:0]    idx,
      input fdcc_cfg_type  c,
      input fdcc_dump_type d,
      input logic          lk
   );
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         4'h0, 4'h1, 4'h2, 4'h3:
            b = d.present_track_value[idx[1:0]];                 // R13
         4'h4: b = {d.step_rate_time, d.delay_after_processing}; // R14
         4'h5: b = {d.delay_before_processing, d.dma_mode};      // R14
         4'h6: b = d.end_of_track_sector;                        // R14
         4'h7: b = {lk, 1'b0, d.per_drive_config,
                    d.group_drive_config};                        // R14
         4'h8: b = {1'b0, c.implied_seek_enable, c.buffer_disable,
                    c.polling_disable, c.buffer_threshold};       // R14
         4'h9: b = c.precomp_start_track;                        // R14
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   assign res_byte = res_inval_r ? INVALID_STATUS
                   : dump_byte(res_idx_r, cfg_r, DUMP_I, LOCK_I);

   // command sequencer
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I || srst) begin
         state_r     <= S_IDLE;
         arg_cnt_r   <= 2'h0;
         res_idx_r   <= 4'h0;
         res_len_r   <= 4'h0;
         res_inval_r <= 1'b0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (data_wr) begin
                  res_idx_r <= 4'h0;
                  if (bus.wdata == OPC_CONFIGURE) begin
                     state_r   <= S_CFG;                         // R1
                     arg_cnt_r <= 2'h0;
                  end else if (bus.wdata == OPC_REGISTER_DUMP) begin
                     state_r     <= S_RESULT;                    // R12
                     res_len_r   <= DUMP_LEN;
                     res_inval_r <= 1'b0;
                  end else begin
                     state_r     <= S_RESULT;                    // R17
                     res_len_r   <= 4'h1;
                     res_inval_r <= 1'b1;
                  end
               end
            end
            S_CFG: begin
               if (data_wr) begin
                  arg_cnt_r <= arg_cnt_r + 2'h1;
                  if (arg_cnt_r == CFG_ARG_COUNT - 2'h1) begin
                     state_r <= S_IDLE;                          // R1
                  end
               end
            end
            S_RESULT: begin
               // writes here are ignored; the result must drain first
               if (data_rd) begin
                  res_idx_r <= res_idx_r + 4'h1;                 // R19
                  if (res_idx_r == res_len_r - 4'h1) begin
                     state_r <= S_IDLE;
                  end
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // configure parameters with lock-aware reset
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         cfg_r.implied_seek_enable <= RST_SEEK_EN;               // R2
         cfg_r.buffer_disable      <= RST_BUF_DIS;               // R2
         cfg_r.polling_disable     <= RST_POLL_DIS;              // R2
         cfg_r.buffer_threshold    <= RST_THR_LVL;               // R2
         cfg_r.precomp_start_track <= RST_PRECOMP;               // R2
      end else if (srst) begin                                   // R15
         cfg_r.implied_seek_enable <= RST_SEEK_EN;               // R9
         cfg_r.polling_disable     <= RST_POLL_DIS;              // R5
         if (!LOCK_I) begin                                      // R16
            cfg_r.buffer_threshold    <= RST_THR_LVL;            // R3
            cfg_r.buffer_disable      <= RST_BUF_DIS;            // R8
            cfg_r.precomp_start_track <= RST_PRECOMP;            // R11
         end                                                     // R18
      end else if (state_r == S_CFG && data_wr) begin
         // second byte is required zero and carries nothing
         if (arg_cnt_r == 2'h1) begin
            cfg_r.implied_seek_enable <= bus.wdata[CFG_SEEK_BIT]; // R1
            cfg_r.buffer_disable      <= bus.wdata[CFG_BUF_BIT];
            cfg_r.polling_disable     <= bus.wdata[CFG_POLL_BIT];
            cfg_r.buffer_threshold    <=
               bus.wdata[CFG_THR_LSB +: CFG_THR_W];              // R3
         end else if (arg_cnt_r == 2'h2) begin
            cfg_r.precomp_start_track <= bus.wdata;              // R11
         end
      end
   end

   // polling window timer; restarted by either reset
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I || srst) begin
         tmr_r     <= TMR_W'(POLL_WINDOW_CYCLES - 1);
         tmr_run_r <= 1'b1;
      end else if (tmr_run_r) begin
         if (cfg_r.polling_disable) begin
            tmr_run_r <= 1'b0;                                   // R7
         end else if (tmr_r == '0) begin
            tmr_run_r <= 1'b0;
         end else begin
            tmr_r <= tmr_r - TMR_W'(1);
         end
      end
   end

   always_comb begin
      int_set = '0;
      int_set[INT_RESET_BIT] = tmr_run_r && tmr_r == '0
                               && !cfg_r.polling_disable;        // R6
      int_set[INT_INVAL_BIT] = state_r == S_IDLE && data_wr
                               && bus.wdata != OPC_CONFIGURE
                               && bus.wdata != OPC_REGISTER_DUMP;
      int_set[INT_DONE_BIT]  = state_r == S_CFG && data_wr
                               && arg_cnt_r == CFG_ARG_COUNT - 2'h1;
   end

   assign int_clr = (bus.wr && bus.addr == OFS_INT_CLR)
                    ? bus.wdata[INT_W-1:0] : '0;

   // set wins over a clear in the same cycle
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         int_st_r <= '0;
      end else begin
         int_st_r <= (int_st_r & ~int_clr) | int_set;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         int_en_r <= '0;
      end else if (bus.wr && bus.addr == OFS_INT_EN) begin
         int_en_r <= bus.wdata[INT_W-1:0];
      end
   end

   // read data, valid in the cycle after the read strobe only
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         RDATA_O <= 8'h00;
      end else if (bus.rd) begin
         case (bus.addr)
            OFS_DATA:
               RDATA_O <= (state_r == S_RESULT) ? res_byte : 8'h00;
            OFS_STATUS: begin
               RDATA_O <= 8'h00;
               RDATA_O[ST_READY_BIT] <= 1'b1;
               RDATA_O[ST_DIR_BIT]   <= state_r == S_RESULT;     // R19
               RDATA_O[ST_BUSY_BIT]  <= state_r != S_IDLE;
            end
            OFS_INT_ST: RDATA_O <= {5'h00, int_st_r};
            OFS_INT_EN: RDATA_O <= {5'h00, int_en_r};
            default:    RDATA_O <= 8'h00;
         endcase
      end else begin
         RDATA_O <= 8'h00;
      end
   end

   // registered control outputs
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         IMPLIED_SEEK_O        <= 1'b0;
         BUFFER_ENABLE_O       <= 1'b0;
         BUFFER_THRESHOLD_O    <= RST_THR_LVL;
         POLLING_ENABLE_O      <= 1'b1;
         PRECOMP_START_TRACK_O <= RST_PRECOMP;
         IRQ_O                 <= 1'b0;
      end else begin
         IMPLIED_SEEK_O  <= cfg_r.implied_seek_enable
                            | MODE_IMPLIED_SEEK_I;               // R10
         BUFFER_ENABLE_O       <= !cfg_r.buffer_disable;         // R8
         BUFFER_THRESHOLD_O    <= cfg_r.buffer_threshold;
         POLLING_ENABLE_O      <= !cfg_r.polling_disable;        // R5
         PRECOMP_START_TRACK_O <= cfg_r.precomp_start_track;
         IRQ_O                 <= |(int_st_r & int_en_r);
      end
   end

endmodule // fdcc_top

// ==== tb/fdcc_props.sv ====
/* port assertions for the configure / dump command slice.
 assumes one clock domain and a host that pauses before each opcode. */
`timescale 1ns/100ps
module fdcc_props
   import fdcc_pkg::*;
#(
   parameter int POLL_WINDOW_CYCLES = 50
)(
   input wire logic                CLK_SYS_I,
   input wire logic                RST_N_I,
   input wire logic [ADDR_W-1:0]   ADDR_I,
   input wire logic [DATA_W-1:0]   WDATA_I,
   input wire logic                WR_I,
   input wire logic                RD_I,
   input wire logic [DATA_W-1:0]   RDATA_O,
   input wire logic                LOCK_I,
   input wire logic                MODE_IMPLIED_SEEK_I,
   input wire fdcc_dump_type       DUMP_I,
   input wire logic                IMPLIED_SEEK_O,
   input wire logic                BUFFER_ENABLE_O,
   input wire logic [CFG_THR_W-1:0] BUFFER_THRESHOLD_O,
   input wire logic                POLLING_ENABLE_O,
   input wire logic [7:0]          PRECOMP_START_TRACK_O,
   input wire logic                IRQ_O
);
   logic srst;
   assign srst = WR_I && ADDR_I == OFS_CTRL && WDATA_I[CTRL_SRST_BIT];
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_wr;
      WR_I && ADDR_I == OFS_DATA;
   endsequence
   // a pause before the opcode keeps argument bytes from matching
   sequence s_op(logic [7:0] op);
      !(WR_I && ADDR_I == OFS_DATA)
         ##1 (WR_I && ADDR_I == OFS_DATA && WDATA_I == op);
   endsequence
   sequence s_rd;
      RD_I && ADDR_I == OFS_DATA;
   endsequence
   property p_cfg;
      logic [7:0] m, t;
      s_op(OPC_CONFIGURE) ##1 s_wr ##1 (s_wr, m = WDATA_I)
         ##1 (s_wr, t = WDATA_I) |-> ##[2:3]
         (BUFFER_THRESHOLD_O == m[3:0] && BUFFER_ENABLE_O == !m[5] &&
          POLLING_ENABLE_O == !m[4] && PRECOMP_START_TRACK_O == t);
   endproperty
   AST_RDATA_QUIET: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
      else $error("read data outside its slot");
   AST_CFG_FIELDS: assert property (p_cfg)
      else $error("configure fields not applied");
   AST_SRST_POLL: assert property (srst |-> ##2 POLLING_ENABLE_O)
      else $error("soft reset left polling off");
   AST_SRST_FREE: assert property (srst && !LOCK_I |-> ##2
      (BUFFER_THRESHOLD_O == 4'h0 && !BUFFER_ENABLE_O &&
       PRECOMP_START_TRACK_O == 8'h00))
      else $error("unlocked soft reset kept values");
   AST_SRST_LOCK: assert property (srst && LOCK_I |-> ##2
      (BUFFER_THRESHOLD_O == $past(BUFFER_THRESHOLD_O, 2) &&
       PRECOMP_START_TRACK_O == $past(PRECOMP_START_TRACK_O, 2)))
      else $error("locked soft reset changed values");
   AST_HW_RESET: assert property (disable iff (1'b0) !RST_N_I |-> ##2
      (BUFFER_THRESHOLD_O == 4'h0 && !BUFFER_ENABLE_O && POLLING_ENABLE_O
       && PRECOMP_START_TRACK_O == 8'h00 && !IRQ_O))
      else $error("hardware reset defaults wrong");
   AST_IMPLIED: assert property (MODE_IMPLIED_SEEK_I |-> ##[1:2] IMPLIED_SEEK_O)
      else $error("mode implied seek not honoured");
   AST_INVALID: assert property (s_op(8'hFF) ##1 s_rd |=>
      RDATA_O == INVALID_STATUS)
      else $error("invalid opcode status wrong");
   AST_DUMP_FIRST: assert property (s_op(OPC_REGISTER_DUMP) ##1 s_rd |=>
      RDATA_O == DUMP_I.present_track_value[0])
      else $error("first dump byte wrong");
endmodule // fdcc_props
bind fdcc_top fdcc_props #(.POLL_WINDOW_CYCLES(POLL_WINDOW_CYCLES))
   fdcc_props_i (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
   .LOCK_I(LOCK_I), .MODE_IMPLIED_SEEK_I(MODE_IMPLIED_SEEK_I),
   .DUMP_I(DUMP_I), .IMPLIED_SEEK_O(IMPLIED_SEEK_O),
   .BUFFER_ENABLE_O(BUFFER_ENABLE_O),
   .BUFFER_THRESHOLD_O(BUFFER_THRESHOLD_O),
   .POLLING_ENABLE_O(POLLING_ENABLE_O),
   .PRECOMP_START_TRACK_O(PRECOMP_START_TRACK_O), .IRQ_O(IRQ_O));

// ==== tb/fdcc_host.sv ====
/* host processor model on the plain register port.
 assumes read data stand in the cycle after the read strobe. */
`timescale 1ns/100ps
module fdcc_host
   import fdcc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic [DATA_W-1:0] rdata_i,
   output logic      [ADDR_W-1:0] addr_o,
   output logic      [DATA_W-1:0] wdata_o,
   output logic                   wr_o,
   output logic                   rd_o
);
   initial begin
      addr_o = 4'h0;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      rd_o <= 1'b0;
   endtask
   // released lines flip so no stale byte looks valid
   task automatic idle();
      @(posedge clk_i);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      addr_o <= ~addr_o;
      wdata_o <= ~wdata_o;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      wr_o <= 1'b0;
      idle();
      #1;
      d = rdata_i;
   endtask
endmodule // fdcc_host

// ==== tb/fdcc_top_bench.sv ====
/* self-checking bench: host model plus a reference model of the
 configure parameters and dump bytes. assumes a 200 MHz clock. */
`timescale 1ns/100ps
module fdcc_top_bench;
   import fdcc_pkg::*;
   localparam int WIN = 50;
   logic          clk, rst_n, lock, mode_is, wr, rd, seek_o, bufen_o;
   logic          pollen_o, irq_o, m_seek, m_bd, m_pd;
   logic [3:0]    addr, thr_o, m_thr;
   logic [7:0]    wdata, rdata, pre_o, m_pre, d;
   logic [31:0]   seed, r;
   logic [63:0]   t;
   logic [7:0]    bad [3] = '{8'hFF, 8'h00, 8'h5B};
   fdcc_dump_type dmp;
   int            errors, check_count;
   fdcc_top #(.POLL_WINDOW_CYCLES(WIN)) fdcc_top_i (.CLK_SYS_I(clk),
      .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .LOCK_I(lock),
      .MODE_IMPLIED_SEEK_I(mode_is), .DUMP_I(dmp), .IMPLIED_SEEK_O(seek_o),
      .BUFFER_ENABLE_O(bufen_o), .BUFFER_THRESHOLD_O(thr_o),
      .POLLING_ENABLE_O(pollen_o), .PRECOMP_START_TRACK_O(pre_o),
      .IRQ_O(irq_o));
   fdcc_host fdcc_host_i (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] v;
      fdcc_host_i.rd(a, v);
      chk(v, e);
   endtask
   task automatic outs();
      chk(8'(thr_o), 8'(m_thr));
      chk(8'(bufen_o), 8'(!m_bd));
      chk(8'(pollen_o), 8'(!m_pd));
      chk(pre_o, m_pre);
      chk(8'(seek_o), 8'(m_seek | mode_is));
   endtask
   task automatic cfg(input logic [7:0] mode, input logic [7:0] pre);
      fdcc_host_i.wr(OFS_DATA, OPC_CONFIGURE);
      fdcc_host_i.wr(OFS_DATA, 8'h00);
      fdcc_host_i.wr(OFS_DATA, mode);
      fdcc_host_i.wr(OFS_DATA, pre);
      fdcc_host_i.idle();
      {m_seek, m_bd, m_pd, m_thr} = mode[6:0];
      m_pre = pre;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic srst();
      fdcc_host_i.wr(OFS_CTRL, 8'h01);
      fdcc_host_i.idle();
      m_seek = 1'b0;
      m_pd = 1'b0;
      if (!lock) begin
         m_thr = 4'h0;
         m_bd = 1'b1;
         m_pre = 8'h00;
      end
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic dump_chk();
      logic [7:0] q[$];
      q = {dmp.present_track_value[0], dmp.present_track_value[1],
         dmp.present_track_value[2], dmp.present_track_value[3],
         8'({dmp.step_rate_time, dmp.delay_after_processing}),
         8'({dmp.delay_before_processing, dmp.dma_mode}),
         dmp.end_of_track_sector,
         8'({lock, 1'b0, dmp.per_drive_config, dmp.group_drive_config}),
         8'({1'b0, m_seek, m_bd, m_pd, m_thr}), m_pre};
      fdcc_host_i.wr(OFS_DATA, OPC_REGISTER_DUMP);
      // an eleventh read must find nothing left
      for (int i = 0; i < 11; i++) begin
         rdchk(OFS_DATA, i < 10 ? q[i] : 8'h00);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      {rst_n, lock, mode_is, errors, check_count, seed} = {3'b0, 64'd0, 32'd99};
      t = {xs(), xs()};
      dmp = fdcc_dump_type'(t[61:0]);
      {m_seek, m_bd, m_pd, m_thr, m_pre} = {3'b010, 12'h000};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      outs();
      fdcc_host_i.wr(OFS_INT_EN, 8'h07);
      rdchk(OFS_INT_EN, 8'h07);
      rdchk(4'hF, 8'h00);
      d = 8'h00;
      for (int i = 0; i < 60 && !d[0]; i++) fdcc_host_i.rd(OFS_INT_ST, d);
      chk(8'(d[0]), 8'h01);
      chk(8'(irq_o), 8'h01);
      fdcc_host_i.wr(OFS_INT_CLR, 8'h07);
      fdcc_host_i.idle();
      @(posedge clk);
      #1;
      chk(8'(irq_o), 8'h00);
      // boundary bytes first, then random host choices of threshold
      for (int k = 0; k < 6; k++) begin
         r = xs();
         if (k < 2) r = k ? 32'h00FF_007F : 32'h0;
         @(posedge clk);
         mode_is <= r[8];
         cfg({1'b0, r[6:0]}, r[23:16]);
         outs();
         dump_chk();
      end
      foreach (bad[i]) begin
         fdcc_host_i.wr(OFS_DATA, bad[i]);
         rdchk(OFS_DATA, INVALID_STATUS);
         rdchk(OFS_DATA, 8'h00);
         rdchk(OFS_STATUS, 8'h80);
      end
      for (int k = 0; k < 2; k++) begin
         cfg(8'h5A, 8'hC3);
         @(posedge clk);
         lock <= k[0];
         srst();
         outs();
         dump_chk();
      end
      @(posedge clk);
      lock <= 1'b0;
      fdcc_host_i.wr(OFS_INT_CLR, 8'h07);
      srst();
      cfg(8'h10, 8'h00);
      repeat (WIN + 10) @(posedge clk);
      fdcc_host_i.rd(OFS_INT_ST, d);
      // only the configure-done bit may stand after the cleared status
      chk(d, 8'h04);
      summarize();
   end
endmodule // fdcc_top_bench
